// File: bench/rmt_host_model.sv
// Host model: register writes, reads and the start command of the no-response timer.
// Assumes the bench calls its tasks and that clock runs free.
`timescale 1ns/10ps
module rmt_host_model (
    input  wire logic             clock,
    output rmt_pkg::rmt_reg_req_t reg_req,
    output logic                  start_cmd,
    input  wire logic [7:0]       rdata
);
    import rmt_pkg::*;

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    initial begin
        reg_req = '0;
        start_cmd = 1'b0;
    end

    // Idle lines show the inverse of the last value, never a stale copy.
    task automatic idle_bus(input logic [5:0] a, input logic [7:0] d);
        reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic write(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(negedge clock);
        idle_bus(a, d);
    endtask

    task automatic read(input logic [5:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        idle_bus(a, 8'h00);
        d = rdata;
    endtask

    // A second command while counting must restart the count.
    task automatic start();
        @(negedge clock);
        start_cmd = 1'b1;
        @(negedge clock);
        start_cmd = 1'b0;
    endtask
endmodule

// File: bench/rmt_rx_timers_tb.sv
// Self-checking bench of the receive window timers.
// Assumes package, defines, design and host model are compiled first.
`timescale 1ns/10ps
`include "rmt_defines.svh"
`define CHK(a, b) begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
        num_errors++; \
        $display("MISMATCH %0t got %h exp %h", $time, a, b); \
    end \
end
module rmt_rx_timers_tb;
    import rmt_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    localparam logic [7:0] ev_tx_end = 8'h80;
    localparam logic [7:0] ev_tx_off = 8'h40;
    localparam logic [7:0] ev_peer   = 8'h10;
    localparam logic [7:0] ev_rx_det = 8'h08;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic         fc_tick = 1'b0;
    rmt_reg_req_t reg_req;
    rmt_events_t  ev = '0;
    rmt_events_t  ev_all;
    logic         start_cmd;
    logic [7:0]   rdata;
    logic         rx_masked;
    logic         nr_running;
    logic         nr_irq;
    logic [7:0]   d;
    int           n;
    int           num_errors = 0;
    int           cmp_count = 0;

    always #5 clock = ~clock;
    // Carrier ticks every other cycle, so counting clocks instead fails.
    always @(negedge clock) fc_tick <= ~fc_tick;
    always_comb begin
        ev_all = ev;
        ev_all.start_nr_cmd = start_cmd;
    end

    rmt_rx_timers u_rmt_rx_timers (
        .clock(clock), .rst(rst), .fc_tick(fc_tick), .reg_req(reg_req),
        .events(ev_all), .rdata(rdata), .rx_masked(rx_masked),
        .nr_running(nr_running), .nr_irq(nr_irq));
    rmt_host_model u_rmt_host_model (
        .clock(clock), .reg_req(reg_req), .start_cmd(start_cmd),
        .rdata(rdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        u_rmt_host_model.write(a, v);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        u_rmt_host_model.read(a, v);
    endtask
    task automatic setnr(input logic [7:0] c, hi, lo);
        wr(`RMT_ADDR_TIMER_CTRL, c);
        wr(`RMT_ADDR_NORESP_HIGH, hi);
        wr(`RMT_ADDR_NORESP_LOW, lo);
    endtask
    task automatic pulse(input logic [7:0] m);
        @(negedge clock);
        ev = rmt_events_t'(ev | m);
        @(negedge clock);
        ev = rmt_events_t'(ev & ~m);
    endtask
    task automatic expect_irq(input int e);
        n = 0;
        while (nr_irq !== 1'b1) begin
            @(negedge clock);
            n++;
            if (n > e + 50) begin
                num_errors++;
                stop_test();
            end
        end
        `CHK(n >= e - 4 && n <= e + 4, 1'b1)
    endtask
    task automatic quiet(input int c);
        logic bad;
        bad = 1'b0;
        repeat (c) begin
            @(negedge clock);
            if (nr_irq !== 1'b0 || nr_running !== 1'b0) bad = 1'b1;
        end
        `CHK(bad, 1'b0)
    endtask
    task automatic mask_run(input logic [7:0] c, v, input int e);
        wr(`RMT_ADDR_TIMER_CTRL, c);
        wr(`RMT_ADDR_MASK_RX, v);
        pulse(ev_tx_end);
        n = 0;
        while (rx_masked === 1'b1 && n < e + 50) begin
            @(negedge clock);
            n++;
        end
        if (rx_masked !== 1'b0) begin
            num_errors++;
            stop_test();
        end
        `CHK(n >= e - 4 && n <= e + 4, 1'b1)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_registers();
        `CHK(rx_masked, 1'b0)
        rd(`RMT_ADDR_MASK_RX, d);
        `CHK(d, `RMT_RST_MASK_RX)
        rd(`RMT_ADDR_NORESP_HIGH, d);
        `CHK(d, `RMT_RST_NORESP)
        rd(`RMT_ADDR_TIMER_CTRL, d);
        `CHK(d, `RMT_RST_TIMER_CTRL)
        wr(`RMT_ADDR_NORESP_HIGH, 8'ha5);
        wr(`RMT_ADDR_NORESP_LOW, 8'h5a);
        wr(6'h20, 8'hff);
        rd(`RMT_ADDR_NORESP_HIGH, d);
        `CHK(d, 8'ha5)
        rd(`RMT_ADDR_NORESP_LOW, d);
        `CHK(d, 8'h5a)
        rd(6'h20, d);
        `CHK(d, 8'h00)
        setnr(8'h00, 8'h00, 8'h00);
    endtask
    task automatic t_mask();
        mask_run(8'h00, 8'h04, 8 * `RMT_MASK_FINE_STEP);
        mask_run(8'h08, 8'h04, 8 * `RMT_MASK_COARSE_STEP);
        mask_run(8'h00, 8'h00, 0);
    endtask
    task automatic t_timeout();
        setnr(8'h00, 8'h00, 8'h02);
        pulse(ev_tx_end);
        expect_irq(4 * `RMT_NR_FINE_STEP);
        setnr(8'h01, 8'h00, 8'h01);
        pulse(ev_tx_end);
        expect_irq(2 * `RMT_NR_COARSE_STEP);
        setnr(8'h00, 8'h01, 8'h00);
        pulse(ev_tx_end);
        expect_irq(512 * `RMT_NR_FINE_STEP);
        setnr(8'h00, 8'h00, 8'h00);
        pulse(ev_tx_end);
        u_rmt_host_model.start();
        quiet(600);
    endtask
    task automatic t_abort();
        setnr(8'h00, 8'h00, 8'h02);
        pulse(ev_tx_end);
        repeat (50) @(negedge clock);
        `CHK(nr_running, 1'b1)
        pulse(ev_rx_det);
        repeat (2) @(negedge clock);
        quiet(400);
    endtask
    task automatic t_nfc_wait();
        ev.nfc_mode = 1'b1;
        pulse(ev_tx_end);
        quiet(400);
        @(negedge clock);
        ev.ext_field = 1'b1;
        expect_irq(4 * `RMT_NR_FINE_STEP);
        @(negedge clock);
        ev = '0;
    endtask
    task automatic t_active();
        ev.active_peer_link = 1'b1;
        pulse(ev_tx_off);
        expect_irq(4 * `RMT_NR_FINE_STEP);
        wr(`RMT_ADDR_TIMER_CTRL, 8'h04);
        pulse(ev_tx_off);
        quiet(400);
        pulse(ev_peer);
        expect_irq(4 * `RMT_NR_FINE_STEP);
        @(negedge clock);
        ev = '0;
    endtask
    task automatic t_restart();
        setnr(8'h00, 8'h00, 8'h02);
        u_rmt_host_model.start();
        repeat (100) @(negedge clock);
        u_rmt_host_model.start();
        expect_irq(4 * `RMT_NR_FINE_STEP);
    endtask

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        t_registers();
        t_mask();
        t_timeout();
        t_abort();
        t_nfc_wait();
        t_active();
        t_restart();
        stop_test();
    end
endmodule

// File: design/rmt_rx_timers.sv
// Register file and timer control for the receive window.
// Assumes fc_tick and events are synchronous to clock; events are single-cycle pulses except the levels nfc_mode, active_peer_link and ext_field.
`timescale 1ns/10ps
`include "rmt_defines.svh"
module rmt_rx_timers (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  fc_tick,
    input  wire rmt_pkg::rmt_reg_req_t reg_req,
    input  wire rmt_pkg::rmt_events_t  events,
    output logic [7:0]                 rdata,
    output logic                       rx_masked,
    output logic                       nr_running,
    output logic                       nr_irq
);
    import rmt_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    mask_receive_time;
        logic [7:0]    no_response_time_high;
        logic [7:0]    no_response_time_low;
        logic [7:0]    timer_ctrl;
        logic [7:0]    rdata;
        logic          rx_masked;
        logic          nr_running;
        logic          nr_irq;
        rmt_nr_state_t nr_state;
    } rmt_top_state_t;

    rmt_top_state_t st_reg;
    rmt_top_state_t st_next;

    logic [15:0] nr_value;
    logic [12:0] mask_step;
    logic [12:0] nr_step;
    logic        mask_busy;
    logic        mask_done;
    logic        nr_busy;
    logic        nr_done;
    logic        nr_load;
    logic        nr_stop;
    logic        nr_trigger;

    assign nr_value = {st_reg.no_response_time_high,
                       st_reg.no_response_time_low};

    // Step length selection.
    assign mask_step = st_reg.timer_ctrl[`RMT_BIT_MASK_STEP] ?
                       `RMT_MASK_COARSE_STEP :
                       `RMT_MASK_FINE_STEP;
    assign nr_step = st_reg.timer_ctrl[`RMT_BIT_NR_STEP] ?
                     `RMT_NR_COARSE_STEP :
                     `RMT_NR_FINE_STEP;

    // ----------------------------------------------------------------
    // Start event selection
    // ----------------------------------------------------------------
    always_comb begin
        if (events.active_peer_link) begin
            nr_trigger = st_reg.timer_ctrl[`RMT_BIT_NR_START_SEL] ?
                         events.peer_field_on :
                         events.tx_off;
        end else begin
            nr_trigger = events.tx_end;
        end
    end

    // A waiting NFC start is held as ARMED until the field shows up or a start command comes.
    always_comb begin
        st_next       = st_reg;
        st_next.rdata = 8'h00;
        nr_load       = 1'b0;
        nr_stop       = 1'b0;
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                `RMT_ADDR_MASK_RX: begin
                    st_next.mask_receive_time = reg_req.wdata;
                end
                `RMT_ADDR_NORESP_HIGH: begin
                    st_next.no_response_time_high = reg_req.wdata;
                end
                `RMT_ADDR_NORESP_LOW: begin
                    st_next.no_response_time_low = reg_req.wdata;
                end
                `RMT_ADDR_TIMER_CTRL: begin
                    st_next.timer_ctrl = reg_req.wdata;
                end
                default: begin
                end
            endcase
        end
        if (reg_req.rd_en) begin
            case (reg_req.addr)
                `RMT_ADDR_MASK_RX: begin
                    st_next.rdata = st_reg.mask_receive_time;
                end
                `RMT_ADDR_NORESP_HIGH: begin
                    st_next.rdata = st_reg.no_response_time_high;
                end
                `RMT_ADDR_NORESP_LOW: begin
                    st_next.rdata = st_reg.no_response_time_low;
                end
                `RMT_ADDR_TIMER_CTRL: begin
                    st_next.rdata = st_reg.timer_ctrl;
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
        case (st_reg.nr_state)
            RMT_NR_IDLE: begin
                if (nr_value != 16'h0000 &&
                    (nr_trigger || events.start_nr_cmd)) begin
                    if (events.nfc_mode && !events.ext_field &&
                        !events.start_nr_cmd) begin
                        st_next.nr_state = RMT_NR_ARMED;
                    end else begin
                        nr_load          = 1'b1;
                        st_next.nr_state = RMT_NR_COUNT;
                    end
                end
            end
            RMT_NR_ARMED: begin
                if (events.ext_field || events.start_nr_cmd) begin
                    nr_load          = 1'b1;
                    st_next.nr_state = RMT_NR_COUNT;
                end
            end
            RMT_NR_COUNT: begin
                if (events.start_nr_cmd) begin
                    nr_load = 1'b1;
                end else if (events.rx_detect) begin
                    nr_stop          = 1'b1;
                    st_next.nr_state = RMT_NR_IDLE;
                end else if (!nr_busy) begin
                    st_next.nr_state = RMT_NR_IDLE;
                end
            end
            default: begin
                st_next.nr_state = RMT_NR_IDLE;
            end
        endcase
        if (nr_value == 16'h0000) begin
            nr_load          = 1'b0;
            st_next.nr_state = RMT_NR_IDLE;
        end
        st_next.nr_irq     = nr_done && !events.rx_detect &&
                             (nr_value != 16'h0000);
        st_next.nr_running = nr_busy;
        st_next.rx_masked  = mask_busy || events.tx_end;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg                       <= '0;
            st_reg.mask_receive_time     <= `RMT_RST_MASK_RX;
            st_reg.no_response_time_high <= `RMT_RST_NORESP;
            st_reg.no_response_time_low  <= `RMT_RST_NORESP;
            st_reg.timer_ctrl            <= `RMT_RST_TIMER_CTRL;
            st_reg.nr_state              <= RMT_NR_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // Mask reload on every end of transmission so back-to-back frames
    // each get their full blanking time.
    rmt_step_timer u_mask_timer (
        .clock    (clock),
        .rst      (rst),
        .fc_tick  (fc_tick),
        .load     (events.tx_end),
        .stop     (1'b0),
        .steps    ({8'h00, st_reg.mask_receive_time}),
        .step_len (mask_step),
        .busy     (mask_busy),
        .done     ()
    );

    rmt_step_timer u_nr_timer (
        .clock    (clock),
        .rst      (rst),
        .fc_tick  (fc_tick),
        .load     (nr_load),
        .stop     (nr_stop),
        .steps    (nr_value),
        .step_len (nr_step),
        .busy     (nr_busy),
        .done     (nr_done)
    );

    assign rdata      = st_reg.rdata;
    assign rx_masked  = st_reg.rx_masked;
    assign nr_running = st_reg.nr_running;
    assign nr_irq     = st_reg.nr_irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_mask_after_tx: assert property (@(posedge clock) disable iff (rst)
        events.tx_end |=> rx_masked)
        else $error("Receiver not masked after end of transmission.");
    a_zero_no_irq: assert property (@(posedge clock) disable iff (rst)
        (nr_value == 16'h0000) |=> !nr_irq)
        else $error("No-response interrupt with zero timeout.");
    a_zero_no_load: assert property (@(posedge clock) disable iff (rst)
        (nr_value == 16'h0000) |-> !nr_load)
        else $error("No-response timer started with zero timeout.");
    a_restart_cmd: assert property (@(posedge clock) disable iff (rst)
        (st_reg.nr_state == RMT_NR_COUNT && events.start_nr_cmd
         && nr_value != 16'h0000) |-> nr_load)
        else $error("Start command did not restart the timer.");
    a_nfc_wait: assert property (@(posedge clock) disable iff (rst)
        (st_reg.nr_state == RMT_NR_ARMED && !events.ext_field
         && !events.start_nr_cmd) |-> !nr_load)
        else $error("NFC start without external field.");
    a_peer_start: assert property (@(posedge clock) disable iff (rst)
        (st_reg.nr_state == RMT_NR_IDLE && events.active_peer_link
         && !st_reg.timer_ctrl[2] && events.tx_off && !events.nfc_mode
         && nr_value != 16'h0000) |-> nr_load)
        else $error("Active peer start missing at transmitter off.");
    a_mask_step: assert property (@(posedge clock) disable iff (rst)
        mask_step == (st_reg.timer_ctrl[3] ? 13'h0200 : 13'h0040))
        else $error("Mask step length wrong.");
    a_nr_step: assert property (@(posedge clock) disable iff (rst)
        nr_step == (st_reg.timer_ctrl[0] ? 13'h1000 : 13'h0040))
        else $error("No-response step length wrong.");
    a_irq_pulse: assert property (@(posedge clock) disable iff (rst)
        nr_irq |=> !nr_irq)
        else $error("Interrupt longer than one cycle.");
endmodule

// File: design/rmt_step_timer.sv
// Down counter that counts a programmed number of steps of a given
// length in carrier periods. Assumes fc_tick pulses once per carrier period.
`timescale 1ns/10ps
module rmt_step_timer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        fc_tick,
    input  wire logic        load,
    input  wire logic        stop,
    input  wire logic [15:0] steps,
    input  wire logic [12:0] step_len,
    output logic             busy,
    output logic             done
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [15:0] steps_left;
        logic [12:0] pre_left;
    } rmt_tmr_state_t;

    rmt_tmr_state_t st_reg;
    rmt_tmr_state_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (load) begin
            // Reload always wins, so a restart clears a running count.
            st_next.busy       = (steps != 16'h0000);
            st_next.steps_left = steps;
            st_next.pre_left   = step_len;
        end else if (stop) begin
            st_next.busy = 1'b0;
        end else if (st_reg.busy && fc_tick) begin
            if (st_reg.pre_left == 13'h0001) begin
                st_next.pre_left = step_len;
                if (st_reg.steps_left == 16'h0001) begin
                    st_next.busy = 1'b0;
                    st_next.done = 1'b1;
                end
                st_next.steps_left = st_reg.steps_left - 16'h0001;
            end else begin
                st_next.pre_left = st_reg.pre_left - 13'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy;
    assign done = st_reg.done;
endmodule

// File: shared/rmt_defines.svh
// Offsets, field positions, reset values and step sizes of the receive
// window timers. Assumes it is included by the bench and design files.
`ifndef RMT_DEFINES_SVH
`define RMT_DEFINES_SVH
`define RMT_ADDR_MASK_RX      6'h0f
`define RMT_ADDR_NORESP_HIGH  6'h10
`define RMT_ADDR_NORESP_LOW   6'h11
`define RMT_ADDR_TIMER_CTRL   6'h12
`define RMT_RST_MASK_RX       8'h08
`define RMT_RST_NORESP        8'h00
`define RMT_RST_TIMER_CTRL    8'h00
`define RMT_BIT_MASK_STEP     3
`define RMT_BIT_NR_START_SEL  2
`define RMT_BIT_NR_STEP       0
`define RMT_MASK_FINE_STEP    13'h0040
`define RMT_MASK_COARSE_STEP  13'h0200
`define RMT_NR_FINE_STEP      13'h0040
`define RMT_NR_COARSE_STEP    13'h1000
`endif

// File: shared/rmt_pkg.sv
// Types shared by the receive window timer files.
// Assumes rmt_defines.svh is on the include path.
package rmt_pkg;
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rmt_reg_req_t;

    typedef struct packed {
        logic tx_end;
        logic tx_off;
        logic ext_field;
        logic peer_field_on;
        logic rx_detect;
        logic start_nr_cmd;
        logic nfc_mode;
        logic active_peer_link;
    } rmt_events_t;

    typedef enum logic [1:0] {
        RMT_NR_IDLE   = 2'b00,
        RMT_NR_ARMED  = 2'b01,
        RMT_NR_COUNT  = 2'b10
    } rmt_nr_state_t;
endpackage
